// *** design/uart_pkg.sv ***
// Purpose: Constants for the dual serial port block
// Assumes: Byte-wide special function register access
// Notes: Offsets are register addresses, not byte lanes
package uart_pkg;
  // ==========================================
  // Register addresses
  localparam logic [7:0] power_control_addr = 8'h87;
  localparam logic [7:0] port0_control_addr = 8'h98;
  localparam logic [7:0] port0_buffer_addr = 8'h99;
  localparam logic [7:0] port1_control_addr = 8'h9b;
  localparam logic [7:0] port1_buffer_addr = 8'h9c;
  localparam logic [7:0] port1_reload_low_addr = 8'h9d;
  localparam logic [7:0] port0_reload_low_addr = 8'haa;
  localparam logic [7:0] port0_reload_high_addr = 8'hba;
  localparam logic [7:0] port1_reload_high_addr = 8'hbb;
  localparam logic [7:0] baud_source_addr = 8'hd8;
  // ==========================================
  // Reset values
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] reload_low_reset = 8'hd9;
  localparam logic [1:0] reload_high_reset = 2'h3;
  // ==========================================
  // Control field positions
  localparam int mode_hi_bit = 7;
  localparam int mode_lo_bit = 6;
  localparam int multiproc_bit = 5;
  localparam int rx_enable_bit = 4;
  localparam int tx_ninth_bit = 3;
  localparam int rx_ninth_bit = 2;
  localparam int tx_done_bit = 1;
  localparam int rx_done_bit = 0;
  localparam int rate_double_bit = 7;
  localparam int baud_source_bit = 7;
  // ==========================================
  // Rate divisors
  localparam int timer_divisor = 384;
  localparam int gen0_divisor = 64;
  localparam int gen1_divisor = 32;
  localparam int fixed_divisor = 64;
  localparam int oversample = 16;
endpackage

// *** design/dual_uart.sv ***
// Purpose: Two serial ports with rate generators behind register access
// Assumes: One clock as processor clock; synchronous active high reset
// Notes: Each port oversamples bits by 16 from its rate tick
`timescale 1ns/1ps
`default_nettype none
module dual_uart
(
  input wire logic clock,
  input wire logic reset,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Timer 1 overflow context
  input wire logic [7:0] timer1_high_byte,
  input wire logic timer1_tick,
  // Serial lines
  input wire logic port0_rxd,
  output logic port0_txd,
  input wire logic port1_rxd,
  output logic port1_txd
);
  // ==========================================
  // Registers
  logic [7:0] ctl_q [2];
  logic [7:0] rbuf_q [2];
  logic [7:0] rel_lo_q [2];
  logic [1:0] rel_hi_q [2];
  logic power_q, source_q;
  logic [1:0] set_tx, set_rx;
  logic [1:0] rx_n9 [2];
  function automatic logic hit(input logic [7:0] a);
    return reg_write && reg_addr == a;
  endfunction
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      power_q <= 1'b0;
      source_q <= 1'b0;
      for (int p = 0; p < 2; p++)
      begin
        rel_lo_q[p] <= uart_pkg::reload_low_reset;
        rel_hi_q[p] <= uart_pkg::reload_high_reset;
      end
    end
    else
    begin
      if (hit(uart_pkg::power_control_addr))
        power_q <= reg_wdata[uart_pkg::rate_double_bit];
      if (hit(uart_pkg::baud_source_addr))
        source_q <= reg_wdata[uart_pkg::baud_source_bit];
      if (hit(uart_pkg::port0_reload_low_addr))
        rel_lo_q[0] <= reg_wdata;
      if (hit(uart_pkg::port0_reload_high_addr))
        rel_hi_q[0] <= reg_wdata[1:0];
      if (hit(uart_pkg::port1_reload_low_addr))
        rel_lo_q[1] <= reg_wdata;
      if (hit(uart_pkg::port1_reload_high_addr))
        rel_hi_q[1] <= reg_wdata[1:0];
    end
  end
  // Flags: hardware set wins over a software clear in the same cycle
  for (genvar p = 0; p < 2; p++)
  begin : g_ctl
    logic wr;
    logic [7:0] w;
    assign wr = hit(p == 0 ? uart_pkg::port0_control_addr : uart_pkg::port1_control_addr);
    assign w = reg_wdata;
    always_ff @(posedge clock)
    begin
      if (reset)
        ctl_q[p] <= uart_pkg::control_reset;
      else
      begin
        if (wr)
          ctl_q[p][7:3] <= w[7:3];
        if (set_rx[p])
          ctl_q[p][uart_pkg::rx_ninth_bit] <= rx_n9[p][0];
        else if (wr && !w[uart_pkg::rx_ninth_bit])
          ctl_q[p][uart_pkg::rx_ninth_bit] <= 1'b0;
        if (set_tx[p])
          ctl_q[p][uart_pkg::tx_done_bit] <= 1'b1;
        else if (wr && !w[uart_pkg::tx_done_bit])
          ctl_q[p][uart_pkg::tx_done_bit] <= 1'b0;
        if (set_rx[p])
          ctl_q[p][uart_pkg::rx_done_bit] <= 1'b1;
        else if (wr && !w[uart_pkg::rx_done_bit])
          ctl_q[p][uart_pkg::rx_done_bit] <= 1'b0;
      end
    end
  end
  // ==========================================
  // Rate generation, ticks at 16x bit rate
  logic [9:0] gen_q [2];
  logic [1:0] gen_ovf;
  logic [4:0] pre_q [2];
  logic base0;
  logic [1:0] os_tick;
  logic [4:0] pre_lim [2];
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      for (int p = 0; p < 2; p++)
      begin
        gen_q[p] <= 10'h000;
        pre_q[p] <= 5'h00;
      end
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (gen_q[p] == 10'h3ff)
          gen_q[p] <= {rel_hi_q[p], rel_lo_q[p]};
        else
          gen_q[p] <= gen_q[p] + 10'h001;
        if (os_tick[p])
          pre_q[p] <= 5'h00;
        else if (p == 0 ? base0 : gen_ovf[1])
          pre_q[p] <= pre_q[p] + 5'h01;
      end
    end
  end
  assign gen_ovf[0] = gen_q[0] == 10'h3ff;
  assign gen_ovf[1] = gen_q[1] == 10'h3ff;
  // Pre-scaler counts only source events, so a slow generator keeps its phase
  assign base0 = ctl_q[0][7:6] == 2'b10 ? 1'b1 : source_q ? gen_ovf[0] : timer1_tick;
  // Port 0 generator: 4 overflows per sample, 2 when doubling
  // Timer source: timer1_tick is the timer 1 overflow (rate already /12 * (256-high byte)), 32 per bit, 16 when doubling
  always_comb
  begin
    if (ctl_q[0][7:6] == 2'b10)
      pre_lim[0] = power_q ? 5'd1 : 5'd3;
    else if (source_q)
      pre_lim[0] = power_q ? 5'd1 : 5'd3;
    else
      pre_lim[0] = power_q ? 5'd0 : 5'd1;
    pre_lim[1] = 5'd1;
  end
  assign os_tick[0] = base0 && pre_q[0] == pre_lim[0];
  assign os_tick[1] = gen_ovf[1] && pre_q[1] == pre_lim[1];
  // ==========================================
  // Per-port transmitter and receiver
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    logic nine;
    logic [10:0] tsh_q;
    logic [3:0] tbits_q, tos_q;
    logic tbusy_q, txd_q;
    logic [9:0] rsh_q;
    logic [3:0] rbits_q, ros_q;
    logic rbusy_q, rxd;
    logic bufw;
    assign nine = p == 0 ? ctl_q[0][uart_pkg::mode_hi_bit] : !ctl_q[1][uart_pkg::mode_hi_bit];
    assign rxd = p == 0 ? port0_rxd : port1_rxd;
    assign bufw = hit(p == 0 ? uart_pkg::port0_buffer_addr : uart_pkg::port1_buffer_addr);
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        tbusy_q <= 1'b0;
        txd_q <= 1'b1;
        tsh_q <= 11'h7ff;
        tbits_q <= 4'h0;
        tos_q <= 4'h0;
        set_tx[p] <= 1'b0;
      end
      else
      begin
        set_tx[p] <= 1'b0;
        if (bufw)
        begin
          tbusy_q <= 1'b1;
          tsh_q <= {1'b1, nine ? ctl_q[p][uart_pkg::tx_ninth_bit] : 1'b1, reg_wdata, 1'b0};
          tbits_q <= nine ? 4'd11 : 4'd10;
          tos_q <= 4'h0;
        end
        else if (tbusy_q && os_tick[p])
        begin
          tos_q <= tos_q + 4'h1;
          if (tos_q == 4'h0)
          begin
            txd_q <= tsh_q[0];
            tsh_q <= {1'b1, tsh_q[10:1]};
            tbits_q <= tbits_q - 4'h1;
          end
          if (tos_q == 4'hf && tbits_q == 4'h0)
          begin
            tbusy_q <= 1'b0;
            set_tx[p] <= 1'b1;
          end
        end
      end
    end
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        rbusy_q <= 1'b0;
        rsh_q <= 10'h000;
        rbits_q <= 4'h0;
        ros_q <= 4'h0;
        rbuf_q[p] <= 8'h00;
        rx_n9[p] <= 2'b00;
        set_rx[p] <= 1'b0;
      end
      else
      begin
        set_rx[p] <= 1'b0;
        if (!rbusy_q)
        begin
          if (os_tick[p] && !rxd && ctl_q[p][uart_pkg::rx_enable_bit])
          begin
            rbusy_q <= 1'b1;
            ros_q <= 4'h1;
            // Stop bit is sampled too, so the frame ends mid stop
            rbits_q <= nine ? 4'd11 : 4'd10;
          end
        end
        else if (os_tick[p])
        begin
          ros_q <= ros_q + 4'h1;
          if (ros_q == 4'h8)
          begin
            rsh_q <= {rxd, rsh_q[9:1]};
            rbits_q <= rbits_q - 4'h1;
            if (rbits_q == 4'h1)
            begin
              rbusy_q <= 1'b0;
              // Multiprocessor filter drops frames whose ninth bit is zero
              if (!(nine && ctl_q[p][uart_pkg::multiproc_bit] && !rsh_q[9]))
              begin
                set_rx[p] <= 1'b1;
                rbuf_q[p] <= nine ? rsh_q[8:1] : rsh_q[9:2];
                rx_n9[p] <= {1'b0, nine ? rsh_q[9] : rxd};
              end
            end
            else if (rbits_q == (nine ? 4'd11 : 4'd10) && rxd)
              rbusy_q <= 1'b0;
          end
        end
      end
    end
    if (p == 0)
    begin : g_o0
      always_ff @(posedge clock)
        port0_txd <= reset ? 1'b1 : txd_q;
    end
    else
    begin : g_o1
      always_ff @(posedge clock)
        port1_txd <= reset ? 1'b1 : txd_q;
    end
  end
  // ==========================================
  // Read mux, registered
  always_ff @(posedge clock)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      unique case (reg_addr)
        uart_pkg::port0_control_addr: reg_rdata <= ctl_q[0];
        uart_pkg::port1_control_addr: reg_rdata <= ctl_q[1];
        uart_pkg::port0_buffer_addr: reg_rdata <= rbuf_q[0];
        uart_pkg::port1_buffer_addr: reg_rdata <= rbuf_q[1];
        uart_pkg::power_control_addr: reg_rdata <= {power_q, 7'h00};
        uart_pkg::baud_source_addr: reg_rdata <= {source_q, 7'h00};
        uart_pkg::port0_reload_low_addr: reg_rdata <= rel_lo_q[0];
        uart_pkg::port1_reload_low_addr: reg_rdata <= rel_lo_q[1];
        uart_pkg::port0_reload_high_addr: reg_rdata <= {6'h00, rel_hi_q[0]};
        uart_pkg::port1_reload_high_addr: reg_rdata <= {6'h00, rel_hi_q[1]};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
  // ==========================================
  // Checks
  a_flag_ones_ignored: assert property (@(posedge clock) disable iff (reset)
    hit(uart_pkg::port0_control_addr) && reg_wdata[1] && !ctl_q[0][1] && !set_tx[0]
    |=> !ctl_q[0][1]) else $error("tx flag set by a written one");
  a_tx_flag_sets: assert property (@(posedge clock) disable iff (reset)
    set_tx[0] |=> ctl_q[0][1]) else $error("tx flag not set");
  a_rx_gated: assert property (@(posedge clock) disable iff (reset)
    !ctl_q[1][4] && !g_port[1].rbusy_q |=> !g_port[1].rbusy_q) else $error("rx while disabled");
  a_tx_starts: assert property (@(posedge clock) disable iff (reset)
    hit(uart_pkg::port1_buffer_addr) |=> g_port[1].tbusy_q) else $error("tx not started");
  a_gen_reload: assert property (@(posedge clock) disable iff (reset)
    gen_ovf[1] |=> gen_q[1] == $past({rel_hi_q[1], rel_lo_q[1]})) else $error("reload wrong");
  a_mp_filter: assert property (@(posedge clock) disable iff (reset)
    set_rx[0] && g_port[0].nine && ctl_q[0][uart_pkg::multiproc_bit] |-> rx_n9[0][0])
    else $error("frame with ninth bit zero flagged");
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
// Purpose: Remote serial party facing both ports
// Assumes: Bit period is given in clocks by the caller
// Notes: Lines idle high between frames, as a pulled-up serial line would
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock
  input wire logic clock,
  // Serial lines, index is the port
  input wire logic [1:0] txd,
  output logic [1:0] rxd
);
  initial rxd = 2'h3;
  // ==========================================
  // Frame sender
  task automatic send(input int p, input int per, input int nb, input logic [8:0] v);
    int i;
    @(posedge clock);
    rxd[p] <= 1'b0;
    repeat (per) @(posedge clock);
    for (i = 0; i < nb; i++)
    begin
      rxd[p] <= v[i];
      repeat (per) @(posedge clock);
    end
    rxd[p] <= 1'b1;
    repeat (per) @(posedge clock);
  endtask
  // ==========================================
  // Frame grabber, samples mid-bit, stop bit lands in the last sampled slot
  task automatic grab(input int p, input int per, input int nb, output logic [9:0] v);
    int i;
    int n;
    v = 10'h0;
    n = 0;
    while (txd[p] !== 1'b0 && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    repeat (per / 2) @(posedge clock);
    for (i = 0; i < nb; i++)
    begin
      repeat (per) @(posedge clock);
      v[i] = txd[p];
    end
  endtask
endmodule
`default_nettype wire

// *** bench/dual_uart_tb.sv ***
// Purpose: Self-checking bench for the dual serial ports
// Assumes: Reload set to all ones, so a generator or fixed-rate bit lasts 32 or 64 clocks, a timer 1 bit 384 or 192
// Notes: Timer tick every 12 clocks, as timer 1 reloading 0xff
`timescale 1ns/1ps
`default_nettype none
module dual_uart_tb;
  typedef struct {logic [7:0] src; logic [7:0] pwr; int p; logic [7:0] ctl; logic [7:0] d; int per; int nb;} row_t;
  logic clock;
  logic reset;
  logic reg_write;
  logic reg_read;
  logic timer1_tick;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] timer1_high_byte;
  wire logic [7:0] reg_rdata;
  wire logic [1:0] txd;
  wire logic [1:0] rxd;
  int err_count = 0;
  int samples_checked = 0;
  int tick_cnt = 0;
  logic [9:0] v;
  logic [7:0] b;
  row_t rows [8] = '{
    '{8'h80, 8'h00, 0, 8'h40, 8'ha5, 64, 8},
    '{8'h80, 8'h80, 0, 8'hc8, 8'h3c, 32, 9},
    '{8'h00, 8'h00, 0, 8'h80, 8'h81, 64, 9},
    '{8'h00, 8'h80, 0, 8'h88, 8'h5a, 32, 9},
    '{8'h00, 8'h00, 0, 8'h40, 8'h96, 384, 8},
    '{8'h00, 8'h80, 0, 8'hc0, 8'h1e, 192, 9},
    '{8'h00, 8'h80, 1, 8'h08, 8'hc3, 32, 9},
    '{8'h80, 8'h00, 1, 8'h80, 8'h7e, 32, 8}};
  dual_uart u_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .timer1_high_byte(timer1_high_byte), .timer1_tick(timer1_tick), .port0_rxd(rxd[0]),
    .port0_txd(txd[0]), .port1_rxd(rxd[1]), .port1_txd(txd[1]));
  host_model u_host (.clock(clock), .txd(txd), .rxd(rxd));
  // ==========================================
  // Register access and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================
  // Clock, timer tick and watchdog
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Timer 1 overflow every 12 clocks, as with a high byte of 0xff
  always @(posedge clock)
  begin
    tick_cnt <= (tick_cnt == 11) ? 0 : tick_cnt + 1;
    timer1_tick <= tick_cnt == 11;
  end
  initial
  begin
    #200000;
    err_count++;
    final_report();
  end
  // ==========================================
  // Tests
  initial
  begin
    reset = 1'b1;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    timer1_high_byte = 8'hff;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd(uart_pkg::port0_control_addr, b);
    chk("ctl0 reset", 10'h000, {2'b00, b});
    rd(uart_pkg::port1_reload_low_addr, b);
    chk("rel1 reset", 10'h0d9, {2'b00, b});
    rd(8'h80, b);
    chk("unmapped", 10'h000, {2'b00, b});
    $display("reset test done");
    // Shortest generator period keeps frames short
    wr(uart_pkg::port0_reload_low_addr, 8'hff);
    wr(uart_pkg::port1_reload_low_addr, 8'hff);
    foreach (rows[i])
    begin
      wr(uart_pkg::baud_source_addr, rows[i].src);
      wr(uart_pkg::power_control_addr, rows[i].pwr);
      wr(rows[i].p ? uart_pkg::port1_control_addr : uart_pkg::port0_control_addr, rows[i].ctl);
      wr(rows[i].p ? uart_pkg::port1_buffer_addr : uart_pkg::port0_buffer_addr, rows[i].d);
      u_host.grab(rows[i].p, rows[i].per, rows[i].nb + 1, v);
      chk("frame", (rows[i].nb == 9) ? {1'b1, rows[i].ctl[3], rows[i].d} : {2'b01, rows[i].d}, v);
      repeat (rows[i].per) @(posedge clock);
      rd(rows[i].p ? uart_pkg::port1_control_addr : uart_pkg::port0_control_addr, b);
      chk("tx done", 10'h001, {9'h0, b[1]});
      $display("row %0d done", i);
    end
    // Address filtering, flag clearing
    wr(uart_pkg::port0_control_addr, 8'hf0);
    u_host.send(0, 64, 9, 9'h012);
    rd(uart_pkg::port0_control_addr, b);
    chk("mp data", 10'h000, {9'h0, b[0]});
    u_host.send(0, 64, 9, 9'h134);
    rd(uart_pkg::port0_control_addr, b);
    chk("mp addr", 10'h001, {9'h0, b[0]});
    rd(uart_pkg::port0_buffer_addr, b);
    chk("rx byte", 10'h034, {2'b00, b});
    wr(uart_pkg::port0_control_addr, 8'hf3);
    rd(uart_pkg::port0_control_addr, b);
    chk("flag kept", 10'h001, {8'h0, b[1:0]});
    wr(uart_pkg::port0_control_addr, 8'hfe);
    rd(uart_pkg::port0_control_addr, b);
    chk("flag clr", 10'h000, {9'h0, b[0]});
    wr(uart_pkg::port0_control_addr, 8'hde);
    u_host.send(0, 64, 9, 9'h056);
    rd(uart_pkg::port0_buffer_addr, b);
    chk("slave data", 10'h056, {2'b00, b});
    $display("address test done");
    // Reception off, then duplex on port 1
    wr(uart_pkg::port1_control_addr, 8'h80);
    u_host.send(1, 32, 8, 9'h0ab);
    rd(uart_pkg::port1_control_addr, b);
    chk("rx off", 10'h000, {9'h0, b[0]});
    wr(uart_pkg::port1_control_addr, 8'h90);
    wr(uart_pkg::port1_buffer_addr, 8'h69);
    fork
      u_host.grab(1, 32, 9, v);
      u_host.send(1, 32, 8, 9'h055);
    join
    chk("duplex tx", 10'h169, v);
    rd(uart_pkg::port1_buffer_addr, b);
    chk("duplex rx", 10'h055, {2'b00, b});
    $display("duplex test done");
    final_report();
  end
endmodule
`default_nettype wire
